// ===== rtl/interval_time_base_timer.sv
// 8-bit interval / clock time-base timer with APB register access.
// Assumes pclk runs in every power state in which the timer counts;
// watch_clk is a free 32.768 kHz level sampled into the pclk domain.
`timescale 1ns/1ps
`include "timer_map.svh"

// Contract
// - Mode bit 3 picks system taps (0) or watch taps (1).
// - Interval select codes pick /8192,/4096,/2048,/512,/256,/128,/32,/8 system taps.
// - Time-base codes give 1 s, 0.5 s, 0.25 s, 0.03125 s periods.
// - Time-base with select bit 2 holds counter and watch prescaler at zero.
// - Counter is 8-bit, read-only, counts one per selected tap pulse.
// - Counter reads work in active mode, not in subactive mode.
// - Pulse at 0xff wraps to 0x00 and sets the overflow flag.
// - Interrupt request only when enable is 1; flag sets regardless.
// - Interval mode overflows once per 256 selected pulses.
// - Reset clears counter and mode bit; interval counting starts at once.
// - Mode bit 4 reads 1 and ignores writes.
// - Interval counter runs in active and sleep; mode writable active/subactive.
// - Time-base counter runs in all but standby and module standby.
// - Watch pulses are synchronised into pclk; up to one pclk of error.
module interval_time_base_timer (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic [11:0]             paddr,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [31:0]             pwdata,
  output logic                         pready,
  output logic [31:0]                  prdata,
  output logic                         pslverr,
  input  wire logic                    watch_clk,
  input  wire timer_pkg::power_state_t power_state,
  output logic                         overflow_request_flag,
  output logic                         overflow_interrupt_request
);

  timer_pkg::timer_state_t st_reg;
  timer_pkg::timer_state_t st_next;

  logic [`SYS_DIV_WIDTH-1:0]   sys_tick;
  logic [`WATCH_DIV_WIDTH-1:0] watch_tick;
  logic                        watch_rise;
  logic                        mode_select_bit;
  logic                        clock_select_bit2;
  logic [1:0]                  watch_sel;
  logic [2:0]                  sys_sel;
  logic                        tb_clear;
  logic                        interval_run;
  logic                        time_base_run;
  logic                        module_halted;
  logic                        count_pulse;
  logic                        overflow;
  logic                        setup_phase;
  logic                        write_strobe;
  logic                        mode_writable;

  // Register view, one aligned word per register:
  //   0x000 mode    [3] source, [2:0] select, [4] reads one,
  //                 [7:5] read zero and are never stored
  //   0x004 count   [7:0] read only; a write is refused
  //   0x008 flag    [0] sticky overflow, write one to clear
  //   0x00c enable  [0] gates the interrupt request
  // Any other address answers with an error and reads zero.
  //
  // Bus timing:
  //   Zero wait states; pready never drops.
  //   Read data and error are latched at the setup edge,
  //   so a read returns the count as it stood one cycle
  //   before the access phase.
  //   Writes land at the access-phase edge.
  //   Mode writes outside active and subactive are dropped
  //   without an error, so the mode is simply retained.
  //
  // Interval source, from the free system prescaler:
  //   code 0 /8192, 1 /4096, 2 /2048, 3 /512,
  //   code 4 /256,  5 /128,  6 /32,   7 /8.
  //   First pulse comes one full tap period after reset.
  //   A code change takes the new tap at its next wrap;
  //   the prescaler is not restarted, which keeps the
  //   change glitch-free but may leave one period short.
  //
  // Time-base source, from the watch prescaler:
  //   code 0 /128, 1 /64, 2 /32, 3 /4 watch rising edges;
  //   256 counts give 1 s, 0.5 s, 0.25 s, 31.25 ms.
  //   Select bit 2 set holds counter and watch prescaler
  //   at zero for as long as it stays set.
  //
  // Power states:
  //   Interval counts in active and sleep only.
  //   Time base counts in all but standby and module
  //   standby; in those two both prescalers freeze too.
  //   The power state comes from logic on pclk, so it is
  //   used without a synchroniser.
  //
  // Overflow:
  //   Pulse at 0xff wraps to zero and sets the flag
  //   on the same edge; a clear in that cycle loses.
  //   The request output is flag and enable, no more;
  //   pending logic lives in the interrupt controller.
  //
  // Reset:
  //   Mode, count, flag and enable clear; read data and
  //   error clear, so the first read after reset is clean.
  //   Both prescalers restart from zero, so interval
  //   counting resumes at once on the /8192 tap.
  //
  // Prescaler sharing:
  //   The system prescaler runs whatever the mode, so a
  //   switch back to interval mode finds it mid-count.
  //   The watch prescaler runs in interval mode too.
  //
  // Limits:
  //   No counter write path exists; software that needs a
  //   fresh period clears it through the time-base hold.
  //   Bits above [7:0] of every register read as zero.
  //   Byte lanes are ignored; every write is a whole word.
  //
  // Hazards:
  //   The watch level is sampled, not used as a clock,
  //   so each time-base period may stretch by one pclk.
  //   The watch clock needs at least eight pclk periods
  //   per cycle, or sampled edges merge and counts drop.
  //   Counter reads in subactive return zero with an
  //   error rather than stale data.
  //   Power state changes take effect on the next edge;
  //   a pulse in flight at that edge is still counted.

  // Tap indices must lie inside their prescalers
  if (`TAP_SYS_8192 >= `SYS_DIV_WIDTH || `TAP_W_1S >= `WATCH_DIV_WIDTH) begin : g_bad_tap
    $error("tap index outside its prescaler");
  end

  // Mode and select fields straight from the mode register
  assign mode_select_bit   = st_reg.mode[`MODE_BIT];
  assign clock_select_bit2 = st_reg.mode[`SEL_BIT2];
  assign sys_sel           = st_reg.mode[2:0];
  assign watch_sel         = st_reg.mode[1:0];

  // Bus phases
  assign setup_phase  = psel & ~penable;
  assign write_strobe = psel & penable & pwrite;

  // Power gating of the two counting modes
  always_comb begin
    interval_run  = 1'b0;
    time_base_run = 1'b0;
    module_halted = 1'b0;
    unique case (power_state)
      timer_pkg::PWR_ACTIVE,
      timer_pkg::PWR_SLEEP: begin
        interval_run  = 1'b1;
        time_base_run = 1'b1;
      end
      timer_pkg::PWR_WATCH,
      timer_pkg::PWR_SUBACTIVE,
      timer_pkg::PWR_SUBSLEEP: begin
        time_base_run = 1'b1;
      end
      timer_pkg::PWR_STANDBY,
      timer_pkg::PWR_MODULE_STANDBY: begin
        module_halted = 1'b1;
      end
      default: begin
        module_halted = 1'b1;
      end
    endcase
  end

  assign mode_writable = (power_state == timer_pkg::PWR_ACTIVE) ||
                         (power_state == timer_pkg::PWR_SUBACTIVE);

  assign tb_clear = mode_select_bit & clock_select_bit2;

  // System prescaler, free running unless the module is halted
  pow2_divider #(
    .WIDTH (`SYS_DIV_WIDTH)
  ) u_sys_prescaler (
    .clk   (pclk),
    .rst_n (presetn),
    .en    (~module_halted),
    .clear (1'b0),
    .tick  (sys_tick)
  );

  level_sync u_watch_sync (
    .clk      (pclk),
    .rst_n    (presetn),
    .async_in (watch_clk),
    .rise     (watch_rise)
  );

  // Watch prescaler counts synchronised watch edges; one pclk of jitter
  // per pulse is the price of staying in a single clock domain.
  pow2_divider #(
    .WIDTH (`WATCH_DIV_WIDTH)
  ) u_watch_prescaler (
    .clk   (pclk),
    .rst_n (presetn),
    .en    (watch_rise & ~module_halted),
    .clear (tb_clear),
    .tick  (watch_tick)
  );

  // Tap selection for the counter clock
  always_comb begin
    count_pulse = 1'b0;
    if (!mode_select_bit) begin
      unique case (sys_sel)
        3'h0: count_pulse = sys_tick[`TAP_SYS_8192];
        3'h1: count_pulse = sys_tick[`TAP_SYS_4096];
        3'h2: count_pulse = sys_tick[`TAP_SYS_2048];
        3'h3: count_pulse = sys_tick[`TAP_SYS_512];
        3'h4: count_pulse = sys_tick[`TAP_SYS_256];
        3'h5: count_pulse = sys_tick[`TAP_SYS_128];
        3'h6: count_pulse = sys_tick[`TAP_SYS_32];
        3'h7: count_pulse = sys_tick[`TAP_SYS_8];
      endcase
      count_pulse = count_pulse & interval_run;
    end else begin
      unique case (watch_sel)
        2'h0: count_pulse = watch_tick[`TAP_W_1S];
        2'h1: count_pulse = watch_tick[`TAP_W_500MS];
        2'h2: count_pulse = watch_tick[`TAP_W_250MS];
        2'h3: count_pulse = watch_tick[`TAP_W_31MS];
      endcase
      count_pulse = count_pulse & time_base_run & ~clock_select_bit2;
    end
  end

  // wrap from 0xff marks an overflow
  assign overflow = count_pulse & (st_reg.count == `COUNT_MAX);

  // Next-state logic: counter, flag, registers and bus read data
  always_comb begin
    st_next = st_reg;

    if (tb_clear) begin
      st_next.count = `COUNT_RESET;
    end else if (count_pulse) begin
      st_next.count = st_reg.count + 8'h01;
    end

    // Register writes; mode bits 7..4 are not stored
    if (write_strobe) begin
      unique case (paddr)
        `OFS_MODE_SELECT: begin
          // upper bits dropped; bit 4 ignored
          if (mode_writable) begin
            st_next.mode = pwdata[3:0];
          end
        end
        `OFS_OVF_FLAG: begin
          // Write one to clear
          if (pwdata[`OVF_FLAG_BIT]) begin
            st_next.ovf_flag = 1'b0;
          end
        end
        `OFS_OVF_ENABLE: begin
          st_next.ovf_enable = pwdata[`OVF_ENABLE_BIT];
        end
        default: begin
        end
      endcase
    end

    if (overflow) begin
      st_next.ovf_flag = 1'b1;
    end

    // Read data and error are captured in the setup cycle so the
    // access phase can finish without a wait state.
    if (setup_phase) begin
      st_next.rdata = 32'h0000_0000;
      st_next.err   = 1'b0;
      unique case (paddr)
        `OFS_MODE_SELECT: begin
          st_next.rdata[`MODE_RSVD_ONE] = 1'b1;
          st_next.rdata[3:0]            = st_reg.mode;
        end
        `OFS_COUNT_VALUE: begin
          if (power_state == timer_pkg::PWR_SUBACTIVE) begin
            st_next.err = 1'b1;
          end else begin
            st_next.rdata[7:0] = st_reg.count;
          end
          st_next.err = st_next.err | pwrite;
        end
        `OFS_OVF_FLAG: begin
          st_next.rdata[`OVF_FLAG_BIT] = st_reg.ovf_flag;
        end
        `OFS_OVF_ENABLE: begin
          st_next.rdata[`OVF_ENABLE_BIT] = st_reg.ovf_enable;
        end
        default: begin
          st_next.err = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg.mode       <= `MODE_RESET;
      st_reg.count      <= `COUNT_RESET;
      st_reg.ovf_flag   <= 1'b0;
      st_reg.ovf_enable <= 1'b0;
      st_reg.rdata      <= 32'h0000_0000;
      st_reg.err        <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Zero-wait slave; error only meaningful in the access phase
  assign pready  = 1'b1;
  assign prdata  = st_reg.rdata;
  assign pslverr = psel & penable & st_reg.err;

  assign overflow_request_flag      = st_reg.ovf_flag;
  assign overflow_interrupt_request = st_reg.ovf_flag & st_reg.ovf_enable;

endmodule

// ===== include/timer_map.svh
// Register offsets, field positions, reset values and clock taps for
// the 8-bit interval / time-base timer.
// Assumes a 32-bit APB slave; each register takes one aligned word.
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH

// Byte offsets on the register bus
`define OFS_MODE_SELECT   12'h000
`define OFS_COUNT_VALUE   12'h004
`define OFS_OVF_FLAG      12'h008
`define OFS_OVF_ENABLE    12'h00c

// Mode register fields
`define MODE_BIT          3
`define SEL_BIT2          2
`define MODE_RSVD_ONE     4
`define MODE_RESET        4'h0
`define COUNT_RESET       8'h00
`define COUNT_MAX         8'hff

// Overflow flag and enable fields
`define OVF_FLAG_BIT      0
`define OVF_ENABLE_BIT    0

// Prescaler widths: system /8192, watch /128
`define SYS_DIV_WIDTH     13
`define WATCH_DIV_WIDTH   7

// Tick index n-1 for a tap of clock/2^n, interval mode
`define TAP_SYS_8192      4'hc
`define TAP_SYS_4096      4'hb
`define TAP_SYS_2048      4'ha
`define TAP_SYS_512       4'h8
`define TAP_SYS_256       4'h7
`define TAP_SYS_128       4'h6
`define TAP_SYS_32        4'h4
`define TAP_SYS_8         4'h2

// Watch taps for overflow periods 1 s, 0.5 s, 0.25 s, 0.03125 s
`define TAP_W_1S          3'h6
`define TAP_W_500MS       3'h5
`define TAP_W_250MS       3'h4
`define TAP_W_31MS        3'h1

`endif

// ===== include/timer_pkg.sv
// Types shared by the timer and its helpers.
// Assumes timer_map.svh supplies the field widths.
package timer_pkg;

  // Device power states, driven by the system power controller
  typedef enum logic [2:0] {
    PWR_ACTIVE,
    PWR_SLEEP,
    PWR_WATCH,
    PWR_SUBACTIVE,
    PWR_SUBSLEEP,
    PWR_STANDBY,
    PWR_MODULE_STANDBY
  } power_state_t;

  // Complete state of the timer top
  typedef struct packed {
    logic [3:0]  mode;
    logic [7:0]  count;
    logic        ovf_flag;
    logic        ovf_enable;
    logic [31:0] rdata;
    logic        err;
  } timer_state_t;

endpackage

// ===== rtl/level_sync.sv
// Two-flop synchroniser with a rising-edge pulse on the far side.
// Assumes the input is slow against clk (several clk periods per level).
`timescale 1ns/1ps
module level_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic async_in,
  output logic      rise
);
  typedef struct packed {
    logic meta;
    logic stable;
    logic last;
  } sync_state_t;

  sync_state_t st_reg;
  sync_state_t st_next;

  // Edge looks only at the second and third flop
  always_comb begin
    st_next.meta   = async_in;
    st_next.stable = st_reg.meta;
    st_next.last   = st_reg.stable;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rise = st_reg.stable & ~st_reg.last;
endmodule

// ===== rtl/pow2_divider.sv
// Binary ripple-free prescaler with one tick per power-of-two tap.
// Assumes en is a one-cycle count pulse; clear holds the count at zero.
`timescale 1ns/1ps
module pow2_divider #(
  parameter int WIDTH = 13
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             en,
  input  wire logic             clear,
  output logic [WIDTH-1:0]      tick
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } div_state_t;

  div_state_t st_reg;
  div_state_t st_next;

  if (WIDTH < 1 || WIDTH > 16) begin : g_bad_width
    $error("pow2_divider WIDTH must be 1 to 16");
  end

  // Clear dominates so a held prescaler stays at zero
  always_comb begin
    st_next = st_reg;
    if (clear) begin
      st_next.cnt = '0;
    end else if (en) begin
      st_next.cnt = st_reg.cnt + WIDTH'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Tap i fires when the low i+1 bits wrap: one tick per 2^(i+1) pulses
  for (genvar i = 0; i < WIDTH; i++) begin : g_tap
    assign tick[i] = en & ~clear & (&st_reg.cnt[i:0]);
  end
endmodule

// ===== verif/timer_assertions.sv
// Port checker for the interval / time-base timer.
// Assumes zero-wait APB and registers at 0x000 to 0x00c.
`timescale 1ns/1ps
module timer_checker (
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic [11:0]             paddr,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [31:0]             pwdata,
  input wire logic [31:0]             prdata,
  input wire logic                    pslverr,
  input wire timer_pkg::power_state_t power_state,
  input wire logic                    overflow_request_flag,
  input wire logic                    overflow_interrupt_request
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // One transfer: setup then access
  sequence s_xfer(logic [11:0] a, logic w);
    psel && !penable && paddr == a && pwrite == w ##1 psel && penable;
  endsequence
  // Hold write, an idle cycle, then a count read
  sequence s_hold_rd;
    power_state == timer_pkg::PWR_ACTIVE ##0 s_xfer(12'h000, 1'h1) ##0 pwdata[3:2] == 2'h3
      ##1 !psel ##1 s_xfer(12'h004, 1'h0);
  endsequence
  property p_irq_gate;
    overflow_interrupt_request |-> overflow_request_flag;
  endproperty
  property p_flag_clear;
    $fell(overflow_request_flag) |->
      $past(psel && penable && pwrite && paddr == 12'h008 && pwdata[0]);
  endproperty
  property p_mode_rsvd;
    s_xfer(12'h000, 1'h0) |-> prdata[7:4] == 4'h1 && !pslverr;
  endproperty
  property p_cnt_sub;
    power_state == timer_pkg::PWR_SUBACTIVE ##0 s_xfer(12'h004, 1'h0) |->
      pslverr && prdata == 32'h0;
  endproperty
  property p_cnt_act;
    power_state == timer_pkg::PWR_ACTIVE ##0 s_xfer(12'h004, 1'h0) |-> !pslverr;
  endproperty
  property p_cnt_ro;
    s_xfer(12'h004, 1'h1) |-> pslverr;
  endproperty
  property p_hold;
    s_hold_rd |-> prdata[7:0] == 8'h00;
  endproperty
  property p_err_phase;
    pslverr |-> psel && penable && (paddr == 12'h004 ||
      !(paddr inside {12'h000, 12'h008, 12'h00c}));
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("request without flag");
  a_flag_clear: assert property (p_flag_clear) else $error("flag dropped alone");
  a_mode_rsvd: assert property (p_mode_rsvd) else $error("mode upper bits wrong");
  a_cnt_sub: assert property (p_cnt_sub) else $error("subactive read served");
  a_cnt_act: assert property (p_cnt_act) else $error("active read refused");
  a_cnt_ro: assert property (p_cnt_ro) else $error("count write accepted");
  a_hold: assert property (p_hold) else $error("count not held at zero");
  a_err_phase: assert property (p_err_phase) else $error("error outside access");
endmodule
bind interval_time_base_timer timer_checker chk_u (.pclk, .presetn, .paddr, .psel, .penable,
  .pwrite, .pwdata, .prdata, .pslverr, .power_state, .overflow_request_flag,
  .overflow_interrupt_request);

// ===== verif/tb_interval_time_base_timer.sv
// Self-checking bench for the interval / time-base timer.
// Assumes the zero-wait APB slave and offsets of timer_map.svh.
`timescale 1ns/1ps
`include "timer_map.svh"
module tb_interval_time_base_timer;
  logic        pclk, presetn, psel, penable, pwrite, watch_clk, pready, pslverr, e;
  logic        overflow_request_flag, overflow_interrupt_request;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0]  d;
  int          miscompares, checks_done, cyc, t0;
  timer_pkg::power_state_t power_state;
  interval_time_base_timer dut_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .pready, .prdata, .pslverr, .watch_clk, .power_state, .overflow_request_flag,
    .overflow_interrupt_request);
  // System clock, 100 ns
  initial begin
    pclk = 1'h0;
    forever #50 pclk = ~pclk;
  end
  // Watch clock sped up to 16 pclk, phase unrelated to pclk
  initial begin
    watch_clk = 1'h0;
    #137;
    forever #800 watch_clk = ~watch_clk;
  end
  // Hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checks_done++;
    if (g !== x) begin
      miscompares++;
      $display("unexpected %0t got %h want %h", $time, g, x);
    end
  endtask
  // One APB transfer; result left in q and e
  // Ends with one idle cycle, so a following call never re-raises psel at once
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata;
    e = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  // Flag sampled between edges, where it is settled
  task automatic wait_flag;
    do @(negedge pclk); while (overflow_request_flag !== 1'h1);
  endtask
  // Count advance over a window of exactly w cycles
  task automatic win(input int w);
    logic [7:0] a;
    apb(1'h0, `OFS_COUNT_VALUE, 32'h0);
    a = q[7:0];
    repeat (w - 3) @(posedge pclk);
    apb(1'h0, `OFS_COUNT_VALUE, 32'h0);
    d = q[7:0] - a;
  endtask
  task automatic in_range(input logic [7:0] lo, input logic [7:0] hi);
    chk({31'h0, d >= lo && d <= hi}, 32'h1);
  endtask
  task automatic t_reset;
    apb(1'h0, `OFS_MODE_SELECT, 32'h0);
    chk(q, 32'h10);
    apb(1'h0, `OFS_COUNT_VALUE, 32'h0);
    chk(q, 32'h0);
    apb(1'h1, `OFS_MODE_SELECT, 32'h7);
    apb(1'h0, `OFS_MODE_SELECT, 32'h0);
    chk(q, 32'h17);
  endtask
  task automatic t_codes;
    int sh[8] = '{13, 12, 11, 9, 8, 7, 5, 3};
    for (int c = 0; c < 8; c++) begin
      apb(1'h1, `OFS_MODE_SELECT, c);
      win(2 << sh[c]);
      chk(d, 8'h2);
    end
  endtask
  task automatic t_ovf;
    apb(1'h1, `OFS_OVF_FLAG, 32'h1);
    wait_flag();
    t0 = cyc;
    @(posedge pclk);
    apb(1'h0, `OFS_COUNT_VALUE, 32'h0);
    chk(q, 32'h0);
    apb(1'h1, `OFS_OVF_FLAG, 32'h1);
    @(negedge pclk);
    chk(overflow_request_flag, 1'h0);
    @(posedge pclk);
    apb(1'h1, `OFS_OVF_ENABLE, 32'h1);
    wait_flag();
    chk(cyc - t0, 2048);
    chk(overflow_interrupt_request, 1'h1);
    @(posedge pclk);
    apb(1'h1, `OFS_OVF_ENABLE, 32'h0);
    @(negedge pclk);
    chk({overflow_request_flag, overflow_interrupt_request}, 2'h2);
    @(posedge pclk);
  endtask
  task automatic t_refuse;
    apb(1'h1, `OFS_COUNT_VALUE, 32'haa);
    chk(e, 1'h1);
    apb(1'h0, 12'h010, 32'h0);
    chk(e, 1'h1);
    power_state <= timer_pkg::PWR_SUBACTIVE;
    apb(1'h0, `OFS_COUNT_VALUE, 32'h0);
    chk(e, 1'h1);
    chk(q, 32'h0);
  endtask
  task automatic t_power;
    power_state <= timer_pkg::PWR_WATCH;
    win(64);
    chk(d, 8'h0);
    power_state <= timer_pkg::PWR_SLEEP;
    apb(1'h1, `OFS_MODE_SELECT, 32'hb);
    win(64);
    chk(d, 8'h8);
    power_state <= timer_pkg::PWR_ACTIVE;
    apb(1'h0, `OFS_MODE_SELECT, 32'h0);
    chk(q, 32'h17);
  endtask
  task automatic t_tbase;
    int p[4] = '{2048, 1024, 512, 64};
    for (int c = 0; c < 4; c++) begin
      apb(1'h1, `OFS_MODE_SELECT, 32'h8 + c);
      win(4 * p[c]);
      in_range(8'h3, 8'h5);
    end
    power_state <= timer_pkg::PWR_SUBSLEEP;
    win(640);
    in_range(8'h9, 8'hb);
    power_state <= timer_pkg::PWR_STANDBY;
    win(640);
    chk(d, 8'h0);
    power_state <= timer_pkg::PWR_ACTIVE;
    apb(1'h1, `OFS_MODE_SELECT, 32'hc);
    win(640);
    chk({d, q[7:0]}, 16'h0);
  endtask
  task automatic t_rst2;
    presetn <= 1'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, `OFS_MODE_SELECT, 32'h0);
    chk(q, 32'h10);
    apb(1'h0, `OFS_COUNT_VALUE, 32'h0);
    chk(q, 32'h0);
  endtask
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    power_state = timer_pkg::PWR_ACTIVE;
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    t_codes();
    t_ovf();
    t_refuse();
    t_power();
    t_tbase();
    t_rst2();
    wrap_up();
  end
endmodule
